// *** verification/sciot_host_model.sv ***
/* host-side message source for the terminal block
   assumes the bench calls send from one process at a time */
`timescale 1ns/1ns
`default_nettype none
module sciot_host_model
   import sciot_pkg::*;
(
   input  wire logic     core_clk,
   output logic          cmd_valid,
   output sciot_msg_type cmd_msg
);
   initial begin
      cmd_valid = 1'b0;
      cmd_msg = '0;
   end
   // one-cycle message; payload scrambled once the pulse is over
   task automatic send(input sciot_code_type code, input logic [15:0] d0,
                       input logic [15:0] d1);
      @(posedge core_clk);
      cmd_valid <= 1'b1;
      cmd_msg <= '{code, d0, d1};
      @(posedge core_clk);
      cmd_valid <= 1'b0;
      cmd_msg <= sciot_msg_type'(~{code, d0, d1});
   endtask
endmodule
`default_nettype wire

// *** verification/sciot_terminal_chk.sv ***
/* checker on the terminal block ports, bound into the block
   assumes one clock domain and a synchronous active-high reset */
`timescale 1ns/1ns
`default_nettype none
module sciot_terminal_chk
   import sciot_pkg::*;
(
   input wire logic              core_clk,
   input wire logic              sys_rst,
   input wire logic [NUM_OUT-1:0] pin_in,
   input wire logic [NUM_OUT-1:0] pin_out,
   input wire logic              device_ready,
   input wire logic              cmd_valid,
   input wire sciot_msg_type     cmd_msg,
   input wire logic              reply_valid,
   input wire sciot_msg_type     reply_msg,
   input wire logic              monitor_valid,
   input wire sciot_msg_type     monitor_msg,
   input wire logic              power_save,
   input wire logic              reg_read,
   input wire logic [DATA_W-1:0] reg_rdata
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   logic zw;
   logic rdy_cmd;
   assign zw = cmd_msg.data0 == '0 && cmd_msg.data1 == '0;
   assign rdy_cmd = cmd_valid && device_ready;
   read_reply_a: assert property (
      rdy_cmd && zw && cmd_msg.code == TERMINAL_READ_MSG |=> reply_valid)
      else $error("read not answered");
   release_reply_a: assert property (
      rdy_cmd && zw && cmd_msg.code == TERMINAL_RELEASE_MSG |=> reply_valid)
      else $error("release not answered");
   not_ready_a: assert property (
      cmd_valid && !device_ready |=> !reply_valid)
      else $error("reply while not ready");
   set_out_a: assert property (
      rdy_cmd && cmd_msg.code == TERMINAL_SET_MSG && cmd_msg.data0 < 16'h2
      && cmd_msg.data1 < 16'h4 |=> reply_valid
      && pin_out[$past(cmd_msg.data1[1:0])] == $past(cmd_msg.data0[0]))
      else $error("set command not applied");
   status_fmt_a: assert property (
      reply_valid |-> reply_msg.code == TERMINAL_STATUS_MSG
      && reply_msg.data1 == '0 && reply_msg.data0[3:0] == pin_out)
      else $error("status reply malformed");
   query_answer_a: assert property (
      cmd_valid && cmd_msg.code == MONITOR_QUERY_MSG |=> monitor_valid)
      else $error("query not answered");
   monitor_fmt_a: assert property (
      monitor_valid |-> monitor_msg.code == MONITOR_SIGNAL_MSG
      && monitor_msg.data1[15:6] == '0
      && monitor_msg.data1[0] == monitor_msg.data1[1]
      && monitor_msg.data1[2] == monitor_msg.data1[3]
      && monitor_msg.data1[4] == monitor_msg.data1[5])
      else $error("monitor message malformed");
   psave_entry_a: assert property (
      $rose(power_save) |-> $past(pin_in[2], 8) && $past(pin_in[2], 30))
      else $error("power save without input_c held");
   rdata_idle_a: assert property (
      !reg_read |=> reg_rdata == '0)
      else $error("read data outside read cycle");
endmodule
bind sciot_terminal sciot_terminal_chk sciot_terminal_chk_i (
   .core_clk(core_clk), .sys_rst(sys_rst), .pin_in(pin_in),
   .pin_out(pin_out), .device_ready(device_ready), .cmd_valid(cmd_valid),
   .cmd_msg(cmd_msg), .reply_valid(reply_valid), .reply_msg(reply_msg),
   .monitor_valid(monitor_valid), .monitor_msg(monitor_msg),
   .power_save(power_save), .reg_read(reg_read), .reg_rdata(reg_rdata));
`default_nettype wire

// *** verification/sciot_terminal_tb_top.sv ***
/* self-checking bench for the terminal block
   assumes the host model and the bound checker are compiled before it */
`timescale 1ns/1ns
`default_nettype none
`define check_eq(what, exp, got) begin n_tests++; if ((got) !== (exp)) \
   begin mismatches++; $display("wrong value %s expected %h seen %h", \
   what, exp, got); end end
module sciot_terminal_tb_top
   import sciot_pkg::*;
;
   localparam int TD = 4;
   logic          core_clk;
   logic          sys_rst;
   logic [3:0]    pin_in;
   logic [3:0]    pin_out;
   logic          device_ready;
   logic [2:0]    zone_raw;
   logic          cmd_valid;
   sciot_msg_type cmd_msg;
   logic          reply_valid;
   sciot_msg_type reply_msg;
   logic          monitor_valid;
   sciot_msg_type monitor_msg;
   logic          power_save;
   logic [3:0]    zone_group;
   logic [7:0]    reg_addr;
   logic [31:0]   reg_wdata;
   logic          reg_write;
   logic          reg_read;
   logic [31:0]   reg_rdata;
   logic [31:0]   d;
   logic [3:0]    exp_out;
   logic [3:0]    ovr;
   logic [3:0]    g;
   int            mismatches;
   int            n_tests;
   int            idx;
   logic [7:0]    r_addr[5] = '{CTRL_ADDR, HOLD0_ADDR, HOLD1_ADDR,
                                HOLD2_ADDR, 8'h14};
   logic [3:0]    f_in[4] = '{4'h0, 4'h1, 4'h3, 4'h2};
   logic [2:0]    f_zone[4] = '{3'h5, 3'h7, 3'h0, 3'h2};
   logic [2:0]    f_sig[4] = '{3'h5, 3'h0, 3'h7, 3'h7};

   sciot_terminal #(.TICK_DIV(TD)) sciot_terminal_i (
      .core_clk(core_clk), .sys_rst(sys_rst), .pin_in(pin_in),
      .pin_out(pin_out), .device_ready(device_ready), .zone_raw(zone_raw),
      .cmd_valid(cmd_valid), .cmd_msg(cmd_msg), .reply_valid(reply_valid),
      .reply_msg(reply_msg), .monitor_valid(monitor_valid),
      .monitor_msg(monitor_msg), .power_save(power_save),
      .zone_group(zone_group), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));
   sciot_host_model sciot_host_model_i (
      .core_clk(core_clk), .cmd_valid(cmd_valid), .cmd_msg(cmd_msg));

   initial core_clk = 1'b0;
   always #25 core_clk = ~core_clk;

   function automatic logic [15:0] mon_exp(logic [2:0] s);
      return {10'h000, {2{s[2]}}, {2{s[1]}}, {2{s[0]}}};
   endfunction
   function automatic logic [31:0] rst_exp(int i);
      return (i == 0) ? 32'(CTRL_RESET) : (i == 4) ? 32'h0 : 32'(DEF_HOLD_MS);
   endfunction

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_write <= 1'b1;
      @(posedge core_clk);
      reg_write <= 1'b0;
   endtask
   task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge core_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge core_clk);
      reg_read <= 1'b0;
      #1 v = reg_rdata;
   endtask
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   initial begin
      repeat (60000) @(posedge core_clk);
      mismatches++;
      final_report();
   end

   initial begin
      sys_rst = 1'b1;
      pin_in = 4'h0;
      device_ready = 1'b0;
      zone_raw = 3'h0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_write = 1'b0;
      reg_read = 1'b0;
      mismatches = 0;
      n_tests = 0;
      exp_out = 4'h1;
      ovr = 4'h0;
      void'($urandom(20117));
      repeat (16) @(posedge core_clk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         reg_rd(r_addr[i], d);
         `check_eq("reset reg", rst_exp(i), d)
      end
      sciot_host_model_i.send(TERMINAL_READ_MSG, 16'h0, 16'h0);
      #1 `check_eq("reply before ready", 1'b0, reply_valid)
      device_ready <= 1'b1;
      repeat (3) @(posedge core_clk);
      #1 `check_eq("default outputs", 4'h1, pin_out)
      for (int i = 0; i < 8; i++) begin
         idx = $urandom % 4;
         pin_in <= {2'($urandom), 2'b00};
         repeat (4) @(posedge core_clk);
         exp_out[idx] = 1'($urandom);
         ovr[idx] = 1'b1;
         sciot_host_model_i.send(TERMINAL_SET_MSG, 16'(exp_out[idx]), 16'(idx));
         #1 `check_eq("set outputs", exp_out, pin_out)
         `check_eq("set reply", {8'h0, pin_in, exp_out}, reply_msg.data0)
      end
      sciot_host_model_i.send(TERMINAL_SET_MSG, 16'h1, 16'h4);
      #1 `check_eq("bad index reply", 1'b0, reply_valid)
      zone_raw <= 3'h5;
      pin_in <= 4'h0;
      repeat (4) @(posedge core_clk);
      exp_out = (exp_out & ovr) | (4'hB & ~ovr);
      sciot_host_model_i.send(TERMINAL_RELEASE_MSG, 16'h0, 16'h0);
      #1 `check_eq("released outputs", 4'hB, pin_out)
      `check_eq("release monitor", exp_out != 4'hB, monitor_valid)
      for (int i = 0; i < 4; i++) begin
         pin_in <= f_in[i];
         zone_raw <= f_zone[i];
         repeat (5) @(posedge core_clk);
         sciot_host_model_i.send(MONITOR_QUERY_MSG, 16'h0, 16'h0);
         #1 `check_eq("forced signals", mon_exp(f_sig[i]), monitor_msg.data1)
         sciot_host_model_i.send(TERMINAL_READ_MSG, 16'h0, 16'h0);
         #1 `check_eq("input levels", f_in[i], reply_msg.data0[7:4])
      end
      reg_wr(HOLD0_ADDR, 32'h0000000A);
      pin_in <= 4'h4;
      zone_raw <= 3'h0;
      repeat (5000 * TD - 40) @(posedge core_clk);
      `check_eq("power save early", 1'b0, power_save)
      repeat (80) @(posedge core_clk);
      `check_eq("power save entry", 1'b1, power_save)
      pin_in <= 4'h0;
      repeat (2000 * TD - 40) @(posedge core_clk);
      `check_eq("power save held", 1'b1, power_save)
      repeat (80) @(posedge core_clk);
      `check_eq("power save exit", 1'b0, power_save)
      g = CTRL_RESET[CTRL_GRP_LSB +: 4];
      zone_raw <= 3'h1;
      @(posedge core_clk);
      #1 `check_eq("monitor change", 1'b1, monitor_valid)
      `check_eq("monitor states", mon_exp(3'h1), monitor_msg.data1)
      `check_eq("monitor group", 16'(g), monitor_msg.data0)
      repeat (3) @(posedge core_clk);
      zone_raw <= 3'h0;
      repeat (24) @(posedge core_clk);
      `check_eq("alarm held", 1'b1, pin_out[1])
      repeat (40) @(posedge core_clk);
      `check_eq("alarm released", 1'b0, pin_out[1])
      reg_wr(CTRL_ADDR, 32'(CTRL_RESET) & ~32'h00000020);
      repeat (3) @(posedge core_clk);
      `check_eq("alarm active low idle", 1'b1, pin_out[1])
      reg_wr(CTRL_ADDR, 32'(CTRL_RESET) & ~32'h00000022);
      zone_raw <= 3'h1;
      repeat (4) @(posedge core_clk);
      `check_eq("alarm unassociated", 1'b1, pin_out[1])
      reg_rd(STATUS_ADDR, d);
      `check_eq("status reg", 32'h00000103, d)
      reg_wr(CTRL_ADDR, 32'(CTRL_RESET) | 32'h00000001);
      g = 4'(1 + $urandom % 15);
      pin_in <= g;
      repeat (1000 * TD - 40) @(posedge core_clk);
      `check_eq("group too early", 4'h0, zone_group)
      repeat (80) @(posedge core_clk);
      `check_eq("input group", g, zone_group)
      `check_eq("no power save", 1'b0, power_save)
      final_report();
   end
endmodule
`default_nettype wire

// *** verilog/sciot_pkg.sv ***
/*
 * Shared constants, message codes and carrier structs for the scanner
 * I/O terminal control block.
 * Assumes a single 20 MHz core clock and a synchronous active-high reset.
 */
`default_nettype none
package sciot_pkg;
   // clock and time base
   localparam int CLK_PERIOD_NS = 50;
   localparam int MS_NS         = 1000000;
   localparam int TICK_CYCLES   = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int GROUP_HOLD_MS = 1000;
   localparam int PSAVE_ON_MS   = 5000;
   localparam int PSAVE_OFF_MS  = 2000;
   localparam int DEF_HOLD_MS   = 2000;
   localparam int CNT_W         = 16;
   localparam int WORD_W        = 16;
   localparam int ADDR_W        = 8;
   localparam int DATA_W        = 32;
   localparam int NUM_OUT       = 4;
   localparam int NUM_ZONE      = 3;

   // register offsets
   localparam logic [ADDR_W-1:0] CTRL_ADDR   = 8'h00;
   localparam logic [ADDR_W-1:0] HOLD0_ADDR  = 8'h04;
   localparam logic [ADDR_W-1:0] HOLD1_ADDR  = 8'h08;
   localparam logic [ADDR_W-1:0] HOLD2_ADDR  = 8'h0C;
   localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h10;

   // control register fields
   localparam int CTRL_MODE_BIT  = 0;
   localparam int CTRL_ASSOC_LSB = 1;
   localparam int CTRL_RDY_BIT   = 4;
   localparam int CTRL_ACT_LSB   = 5;
   localparam int CTRL_CAN_LSB   = 8;
   localparam int CTRL_EFF_LSB   = 11;
   localparam int CTRL_GRP_LSB   = 14;
   localparam int CTRL_W         = 18;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 18'h03FFE;

   // status register fields
   localparam int ST_IN_LSB  = 4;
   localparam int ST_SIG_LSB = 8;
   localparam int ST_PS_BIT  = 11;
   localparam int ST_OVR_LSB = 12;
   localparam int ST_GRP_LSB = 16;

   typedef enum logic [2:0] {
      TERMINAL_READ_MSG,
      TERMINAL_SET_MSG,
      TERMINAL_RELEASE_MSG,
      TERMINAL_STATUS_MSG,
      MONITOR_SIGNAL_MSG,
      MONITOR_QUERY_MSG
   } sciot_code_type;

   typedef struct packed {
      sciot_code_type    code;
      logic [WORD_W-1:0] data0;
      logic [WORD_W-1:0] data1;
   } sciot_msg_type;
endpackage
`default_nettype wire

// *** verilog/sciot_terminal.sv ***
/*
 * Digital I/O terminal logic: four level inputs, four on/off outputs,
 * host message handling and a small register port for configuration.
 * Assumes raw pins are asynchronous, the zone signals and ready flag come
 * from logic on core_clk, and the host link delivers one message per pulse.
 */
// Summary of operation
// - host zone mode: input_a high cancels, input_b high forces signals
// - input zone mode: four inputs form group 0..15, stable 1 s first
// - host mode: input_c high 5 s enters power save, low 2 s leaves
// - outputs default to ready, alarm, pre-warning, attention, high = on
// - ready output always active high, no hold time
// - active zone output held at least its hold time, 2 s default
// - active level and hold time set per zone output
// - disabled association leaves output unaffected by its signal
// - read with zero words samples terminals, answers status
// - set message gives state and output index, answers status
// - status: outputs bits 0-3, inputs bits 4-7, second word zero
// - host set overrides zone drive until release
// - release with zero words ends override, answers status
// - release that changes any output also sends monitor message
// - monitor query answered with current signal states
// - input_a and input_b levels visible in status read
// - terminal read and control accepted only once ready
// - any signal change sends monitor message: group, states bits 0-5
// - forced effective wins over forced cancel
`timescale 1ns/1ns
`default_nettype none
module sciot_terminal
   import sciot_pkg::*;
#(
   parameter int TICK_DIV = TICK_CYCLES
)(
   input  wire logic                  core_clk,
   input  wire logic                  sys_rst,
   input  wire logic [NUM_OUT-1:0]    pin_in,
   output logic      [NUM_OUT-1:0]    pin_out,
   input  wire logic                  device_ready,
   input  wire logic [NUM_ZONE-1:0]   zone_raw,
   input  wire logic                  cmd_valid,
   input  wire sciot_msg_type         cmd_msg,
   output logic                       reply_valid,
   output sciot_msg_type              reply_msg,
   output logic                       monitor_valid,
   output sciot_msg_type              monitor_msg,
   output logic                       power_save,
   output logic      [3:0]            zone_group,
   input  wire logic [ADDR_W-1:0]     reg_addr,
   input  wire logic [DATA_W-1:0]     reg_wdata,
   input  wire logic                  reg_write,
   input  wire logic                  reg_read,
   output logic      [DATA_W-1:0]     reg_rdata
);
   // synchronisers, tick, qualifiers
   logic [NUM_OUT-1:0] sync1, sync2;
   logic [CNT_W-1:0]   tick_cnt, next_tick_cnt;
   logic               tick;
   logic [CNT_W-1:0]   grp_cnt, next_grp_cnt;
   logic [3:0]         grp_last, next_grp_last;
   logic [3:0]         sel_group, next_sel_group;
   logic [CNT_W-1:0]   ps_cnt, next_ps_cnt;
   logic               next_power_save;
   logic [3:0]         next_zone_group;

   // configuration
   logic [CTRL_W-1:0]  ctrl, next_ctrl;
   logic [CNT_W-1:0]   hold_ms [NUM_ZONE];
   logic [CNT_W-1:0]   next_hold_ms [NUM_ZONE];
   logic               next_rd_pend;
   logic [DATA_W-1:0]  next_rdata;

   wire logic               input_mode = ctrl[CTRL_MODE_BIT];
   wire logic [NUM_ZONE-1:0] assoc = ctrl[CTRL_ASSOC_LSB +: NUM_ZONE];
   wire logic [NUM_ZONE-1:0] act   = ctrl[CTRL_ACT_LSB +: NUM_ZONE];
   wire logic [NUM_ZONE-1:0] canm  = ctrl[CTRL_CAN_LSB +: NUM_ZONE];
   wire logic [NUM_ZONE-1:0] effm  = ctrl[CTRL_EFF_LSB +: NUM_ZONE];

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         sync1 <= '0;
         sync2 <= '0;
      end else begin
         sync1 <= pin_in;
         sync2 <= sync1;
      end
   end

   always_comb begin
      tick = (tick_cnt == CNT_W'(TICK_DIV - 1));
      next_tick_cnt = tick ? '0 : tick_cnt + 1'b1;
      next_grp_last = grp_last;
      next_grp_cnt = grp_cnt;
      next_sel_group = sel_group;
      if (sync2 != grp_last) begin
         next_grp_last = sync2;
         next_grp_cnt = '0;
      end else if (tick && grp_cnt != CNT_W'(GROUP_HOLD_MS)) begin
         next_grp_cnt = grp_cnt + 1'b1;
      end
      if (next_grp_cnt == CNT_W'(GROUP_HOLD_MS))
         next_sel_group = grp_last;
      next_zone_group = input_mode ? sel_group : ctrl[CTRL_GRP_LSB +: 4];
      next_ps_cnt = ps_cnt;
      next_power_save = power_save;
      if (input_mode) begin
         next_ps_cnt = '0;
         next_power_save = 1'b0;
      end else if (sync2[2] == power_save) begin
         next_ps_cnt = '0;
      end else if (tick) begin
         next_ps_cnt = ps_cnt + 1'b1;
         if (!power_save && ps_cnt == CNT_W'(PSAVE_ON_MS - 1)) begin
            next_power_save = 1'b1;
            next_ps_cnt = '0;
         end else if (power_save && ps_cnt == CNT_W'(PSAVE_OFF_MS - 1)) begin
            next_power_save = 1'b0;
            next_ps_cnt = '0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         tick_cnt   <= '0;
         grp_cnt    <= '0;
         grp_last   <= '0;
         sel_group  <= '0;
         ps_cnt     <= '0;
         power_save <= 1'b0;
         zone_group <= CTRL_RESET[CTRL_GRP_LSB +: 4];
      end else begin
         tick_cnt   <= next_tick_cnt;
         grp_cnt    <= next_grp_cnt;
         grp_last   <= next_grp_last;
         sel_group  <= next_sel_group;
         ps_cnt     <= next_ps_cnt;
         power_save <= next_power_save;
         zone_group <= next_zone_group;
      end
   end

   // forced control applies only in host-selected mode
   logic [NUM_ZONE-1:0] zone_sig;
   logic                force_cancel, force_eff;
   assign force_cancel = !input_mode && sync2[0];
   assign force_eff    = !input_mode && sync2[1];
   assign zone_sig = (zone_raw & ~({NUM_ZONE{force_cancel}} & canm))
                   | ({NUM_ZONE{force_eff}} & effm);

   // per-zone minimum active time
   logic [NUM_ZONE-1:0] stretched;
   genvar gi;
   generate
      for (gi = 0; gi < NUM_ZONE; gi++) begin : g_hold
         logic [CNT_W-1:0] hcnt, next_hcnt;
         always_comb begin
            next_hcnt = hcnt;
            if (zone_sig[gi])
               next_hcnt = hold_ms[gi];
            else if (tick && hcnt != '0)
               next_hcnt = hcnt - 1'b1;
         end
         always_ff @(posedge core_clk) begin
            if (sys_rst)
               hcnt <= '0;
            else
               hcnt <= next_hcnt;
         end
         assign stretched[gi] = zone_sig[gi] || hcnt != '0;
      end
   endgenerate

   // output drive and host messages
   logic [NUM_OUT-1:0]  host_val, next_host_val;
   logic [NUM_OUT-1:0]  ovr, next_ovr;
   logic [NUM_OUT-1:0]  next_pin_out, drive;
   logic [NUM_ZONE-1:0] sig_prev;
   logic                next_reply_valid, next_monitor_valid;
   sciot_msg_type       next_reply_msg, next_monitor_msg;
   logic                words_zero, accept;

   always_comb begin
      words_zero = cmd_msg.data0 == '0 && cmd_msg.data1 == '0;
      accept = cmd_valid && device_ready;
      next_ovr = ovr;
      next_host_val = host_val;
      next_reply_valid = 1'b0;
      next_monitor_valid = 1'b0;
      if (accept) begin
         case (cmd_msg.code)
            TERMINAL_READ_MSG: begin
               next_reply_valid = words_zero;
            end
            TERMINAL_SET_MSG: begin
               if (cmd_msg.data0 <= WORD_W'(1)
                   && cmd_msg.data1 < WORD_W'(NUM_OUT)) begin
                  next_ovr[cmd_msg.data1[1:0]] = 1'b1;
                  next_host_val[cmd_msg.data1[1:0]] = cmd_msg.data0[0];
                  next_reply_valid = 1'b1;
               end
            end
            TERMINAL_RELEASE_MSG: begin
               if (words_zero) begin
                  next_ovr = '0;
                  next_reply_valid = 1'b1;
               end
            end
            default: begin
            end
         endcase
      end
      // zone-driven value, or hold the pin when association is off
      drive[0] = ctrl[CTRL_RDY_BIT] ? device_ready : pin_out[0];
      for (int k = 0; k < NUM_ZONE; k++)
         drive[k+1] = assoc[k] ? (stretched[k] ? act[k] : ~act[k])
                               : pin_out[k+1];
      for (int k = 0; k < NUM_OUT; k++)
         next_pin_out[k] = next_ovr[k] ? next_host_val[k] : drive[k];
      next_reply_msg.code = TERMINAL_STATUS_MSG;
      next_reply_msg.data0 = WORD_W'({sync2, next_pin_out});
      next_reply_msg.data1 = '0;
      if (zone_sig != sig_prev)
         next_monitor_valid = 1'b1;
      if (cmd_valid && cmd_msg.code == MONITOR_QUERY_MSG)
         next_monitor_valid = 1'b1;
      if (accept && cmd_msg.code == TERMINAL_RELEASE_MSG && words_zero
          && ovr != '0 && next_pin_out != pin_out)
         next_monitor_valid = 1'b1;
      next_monitor_msg.code = MONITOR_SIGNAL_MSG;
      next_monitor_msg.data0 = WORD_W'(zone_group);
      next_monitor_msg.data1 = '0;
      for (int k = 0; k < NUM_ZONE; k++) begin
         next_monitor_msg.data1[2*k]   = zone_sig[k];
         next_monitor_msg.data1[2*k+1] = zone_sig[k];
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ovr           <= '0;
         host_val      <= '0;
         pin_out       <= '0;
         sig_prev      <= '0;
         reply_valid   <= 1'b0;
         reply_msg     <= '0;
         monitor_valid <= 1'b0;
         monitor_msg   <= '0;
      end else begin
         ovr           <= next_ovr;
         host_val      <= next_host_val;
         pin_out       <= next_pin_out;
         sig_prev      <= zone_sig;
         reply_valid   <= next_reply_valid;
         reply_msg     <= next_reply_msg;
         monitor_valid <= next_monitor_valid;
         monitor_msg   <= next_monitor_msg;
      end
   end

   // register port
   always_comb begin
      next_ctrl = ctrl;
      for (int k = 0; k < NUM_ZONE; k++)
         next_hold_ms[k] = hold_ms[k];
      if (reg_write) begin
         if (reg_addr == CTRL_ADDR)
            next_ctrl = reg_wdata[CTRL_W-1:0];
         else if (reg_addr == HOLD0_ADDR)
            next_hold_ms[0] = reg_wdata[CNT_W-1:0];
         else if (reg_addr == HOLD1_ADDR)
            next_hold_ms[1] = reg_wdata[CNT_W-1:0];
         else if (reg_addr == HOLD2_ADDR)
            next_hold_ms[2] = reg_wdata[CNT_W-1:0];
      end
      next_rdata = '0;
      if (reg_read) begin
         if (reg_addr == CTRL_ADDR)
            next_rdata = DATA_W'(ctrl);
         else if (reg_addr == HOLD0_ADDR)
            next_rdata = DATA_W'(hold_ms[0]);
         else if (reg_addr == HOLD1_ADDR)
            next_rdata = DATA_W'(hold_ms[1]);
         else if (reg_addr == HOLD2_ADDR)
            next_rdata = DATA_W'(hold_ms[2]);
         else if (reg_addr == STATUS_ADDR) begin
            next_rdata[NUM_OUT-1:0] = pin_out;
            next_rdata[ST_IN_LSB +: NUM_OUT] = sync2;
            next_rdata[ST_SIG_LSB +: NUM_ZONE] = zone_sig;
            next_rdata[ST_PS_BIT] = power_save;
            next_rdata[ST_OVR_LSB +: NUM_OUT] = ovr;
            next_rdata[ST_GRP_LSB +: 4] = zone_group;
         end
      end
      next_rd_pend = reg_read;
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ctrl      <= CTRL_RESET;
         reg_rdata <= '0;
         for (int k = 0; k < NUM_ZONE; k++)
            hold_ms[k] <= CNT_W'(DEF_HOLD_MS);
      end else begin
         ctrl      <= next_ctrl;
         reg_rdata <= next_rd_pend ? next_rdata : '0;
         for (int k = 0; k < NUM_ZONE; k++)
            hold_ms[k] <= next_hold_ms[k];
      end
   end
endmodule
`default_nettype wire
